//--- hdl/supply_button_watchdog_supervisor.sv
// Supply, pushbutton and watchdog supervisor for a processor.
// Assumes all inputs are synchronous to clk; analog levels arrive
// already compared as supply_ok and sense_ok.
`timescale 1ns/1ns
`include "supervisor_cfg.svh"

module supply_button_watchdog_supervisor #(
	parameter int unsigned RST_CYC = `RST_CYC,
	parameter int unsigned IRQ_CYC = `IRQ_CYC,
	parameter int unsigned FILT_CYC = `FILT_CYC,
	parameter int unsigned WD_CYC = `WD_CYC,
	parameter int unsigned DEB_CYC = `DEB_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Analog comparator results
	input wire logic supply_ok,
	input wire logic sense_ok,
	// Pushbutton, active low
	input wire logic button_reset_n,
	// Processor strobe
	input wire logic watchdog_kick,
	// Reset outputs
	output logic reset_out_n,
	output logic reset_out,
	// Early power-fail interrupt, active low
	output logic power_fail_irq_n,
	// Watchdog status, active low
	output logic watchdog_flag_n
);
	import supervisor_pkg::*;

	// Saturating increment
	function automatic cnt_t inc(input cnt_t v);
		inc = (v == '1) ? v : cnt_t'(v + cnt_t'(1));
	endfunction : inc

	// Reached a cycle count
	function automatic logic hit(input cnt_t v, input int unsigned n);
		hit = (v >= cnt_t'(n - 1));
	endfunction : hit

	// Debounced button state, 1 = pressed
	logic btn_low_r;
	// Debounce disagreement counter
	cnt_t deb_cnt_r;
	// Reset sequencer state and next
	rst_state_t st_r;
	rst_state_t st_nxt;
	// Stretch counter
	cnt_t st_cnt_r;
	// Hold condition: supply bad or button down
	logic hold;
	// Sense low filter counter
	cnt_t filt_cnt_r;
	// Interrupt may fire once per low excursion
	logic armed_r;
	// Interrupt pulse counter
	cnt_t irq_cnt_r;
	// Filter complete and allowed to fire
	logic fire;
	// Strobe history
	logic kick_prev_r;
	// Falling edge on strobe
	logic kick_fall;
	// Watchdog counter
	cnt_t wd_cnt_r;
	// Watchdog flag stretch counter
	cnt_t wdf_cnt_r;
	// Watchdog flag stretch active
	logic wdf_act_r;

	assign hold = !supply_ok || btn_low_r;
	assign fire = hit(filt_cnt_r, FILT_CYC) && !sense_ok && armed_r && supply_ok;
	assign kick_fall = kick_prev_r && !watchdog_kick;

	// Button debounce: level must persist DEB_CYC cycles
	always_ff @(posedge clk) begin
		if (!nrst) begin
			btn_low_r <= 1'b0;
			deb_cnt_r <= `CNT_ZERO;
		end else if (btn_low_r == !button_reset_n) begin
			// Agrees, nothing pending
			deb_cnt_r <= `CNT_ZERO;
		end else if (hit(deb_cnt_r, DEB_CYC)) begin
			// Stable long enough, accept
			btn_low_r <= !button_reset_n;
			deb_cnt_r <= `CNT_ZERO;
		end else begin
			deb_cnt_r <= inc(deb_cnt_r);
		end
	end

	// Reset sequencer next state
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			RS_HOLD: begin
				// Stretch starts only when hold ends
				if (!hold) begin
					st_nxt = RS_STRETCH;
				end
			end
			RS_STRETCH: begin
				if (hold) begin
					st_nxt = RS_HOLD;
				end else if (hit(st_cnt_r, RST_CYC)) begin
					st_nxt = RS_RUN;
				end
			end
			RS_RUN: begin
				if (hold) begin
					st_nxt = RS_HOLD;
				end
			end
			default: begin
				// Unused code recovers into reset
				st_nxt = RS_HOLD;
			end
		endcase
	end

	// Reset sequencer state; starts held for power-up
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= RS_HOLD;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Stretch counter, cleared outside stretch
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_cnt_r <= `CNT_ZERO;
		end else if (st_nxt == RS_STRETCH && st_r == RS_STRETCH) begin
			st_cnt_r <= inc(st_cnt_r);
		end else begin
			st_cnt_r <= `CNT_ZERO;
		end
	end

	// Both reset polarities from the same next state
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reset_out_n <= 1'b0;
			reset_out <= 1'b1;
		end else begin
			reset_out_n <= (st_nxt == RS_RUN);
			reset_out <= (st_nxt != RS_RUN);
		end
	end

	// Sense filter; suppressed while supply below trip
	always_ff @(posedge clk) begin
		if (!nrst) begin
			filt_cnt_r <= `CNT_ZERO;
		end else if (sense_ok || !supply_ok) begin
			filt_cnt_r <= `CNT_ZERO;
		end else begin
			filt_cnt_r <= inc(filt_cnt_r);
		end
	end

	// One interrupt per excursion; rearm on recovery
	always_ff @(posedge clk) begin
		if (!nrst) begin
			armed_r <= 1'b1;
		end else if (fire) begin
			armed_r <= 1'b0;
		end else if (sense_ok) begin
			armed_r <= 1'b1;
		end
	end

	// Interrupt pulse timer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_cnt_r <= `CNT_ZERO;
			power_fail_irq_n <= 1'b1;
		end else if (fire) begin
			irq_cnt_r <= `CNT_ZERO;
			power_fail_irq_n <= 1'b0;
		end else if (!power_fail_irq_n) begin
			irq_cnt_r <= inc(irq_cnt_r);
			// Release after full width
			if (hit(irq_cnt_r, IRQ_CYC)) begin
				power_fail_irq_n <= 1'b1;
			end
		end
	end

	// Strobe history for edge detect
	always_ff @(posedge clk) begin
		if (!nrst) begin
			kick_prev_r <= 1'b1;
		end else begin
			kick_prev_r <= watchdog_kick;
		end
	end

	// Watchdog counter; frozen at zero under reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wd_cnt_r <= `CNT_ZERO;
		end else if (!reset_out_n) begin
			wd_cnt_r <= `CNT_ZERO;
		end else if (kick_fall) begin
			wd_cnt_r <= `CNT_ZERO;
		end else if (hit(wd_cnt_r, WD_CYC)) begin
			// Timeout; start the next period
			wd_cnt_r <= `CNT_ZERO;
		end else begin
			wd_cnt_r <= inc(wd_cnt_r);
		end
	end

	// Watchdog flag stretch
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wdf_act_r <= 1'b0;
			wdf_cnt_r <= `CNT_ZERO;
			watchdog_flag_n <= 1'b1;
		end else if (reset_out_n && !kick_fall && hit(wd_cnt_r, WD_CYC)) begin
			wdf_act_r <= 1'b1;
			wdf_cnt_r <= `CNT_ZERO;
			watchdog_flag_n <= 1'b0;
		end else if (wdf_act_r) begin
			wdf_cnt_r <= inc(wdf_cnt_r);
			// Release after full width
			if (hit(wdf_cnt_r, RST_CYC)) begin
				wdf_act_r <= 1'b0;
				watchdog_flag_n <= 1'b1;
			end
		end
	end

	// Helper: cycles reset low with hold released
	cnt_t a_rel_r;
	// Helper: interrupt low length
	cnt_t a_irq_r;
	// Helper: consecutive sense-low cycles
	cnt_t a_sen_r;
	// Helper: flag low length
	cnt_t a_wdf_r;

	// Assertion helper counters
	always_ff @(posedge clk) begin
		if (!nrst) begin
			a_rel_r <= `CNT_ZERO;
			a_irq_r <= `CNT_ZERO;
			a_sen_r <= `CNT_ZERO;
			a_wdf_r <= `CNT_ZERO;
		end else begin
			a_rel_r <= (reset_out_n || hold) ? `CNT_ZERO : inc(a_rel_r);
			a_irq_r <= power_fail_irq_n ? `CNT_ZERO : inc(a_irq_r);
			a_sen_r <= sense_ok ? `CNT_ZERO : inc(a_sen_r);
			a_wdf_r <= watchdog_flag_n ? `CNT_ZERO : inc(a_wdf_r);
		end
	end

	chk_reset_supply_low: assert property (
		@(posedge clk) disable iff (!nrst)
		!supply_ok |=> !reset_out_n)
		else $error("reset not asserted on low supply");

	chk_reset_stretch_len: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(reset_out_n) |-> $past(a_rel_r) >= cnt_t'(RST_CYC - 1))
		else $error("reset released before stretch done");

	chk_button_holds_reset: assert property (
		@(posedge clk) disable iff (!nrst)
		btn_low_r |=> !reset_out_n ##1 !reset_out_n)
		else $error("reset released while button pressed");

	chk_button_debounce: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(btn_low_r) |-> $past(!button_reset_n, 1) && $past(!button_reset_n, 2))
		else $error("button accepted without debounce");

	chk_reset_polarity: assert property (
		@(posedge clk) disable iff (!nrst)
		reset_out == !reset_out_n)
		else $error("reset outputs disagree");

	chk_irq_needs_sense: assert property (
		@(posedge clk) disable iff (!nrst)
		$fell(power_fail_irq_n) |-> $past(!sense_ok))
		else $error("interrupt without low sense");

	chk_irq_width: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(power_fail_irq_n) |-> $past(a_irq_r) >= cnt_t'(IRQ_CYC - 1))
		else $error("interrupt pulse too short");

	chk_irq_filter: assert property (
		@(posedge clk) disable iff (!nrst)
		$fell(power_fail_irq_n) |-> $past(a_sen_r) >= cnt_t'(FILT_CYC - 1))
		else $error("interrupt before filter time");

	chk_irq_supply_gate: assert property (
		@(posedge clk) disable iff (!nrst)
		!supply_ok && power_fail_irq_n |=> power_fail_irq_n)
		else $error("interrupt while supply below trip");

	chk_wdog_timeout: assert property (
		@(posedge clk) disable iff (!nrst)
		$fell(watchdog_flag_n) |-> wd_cnt_r == `CNT_ZERO
			&& $past(wd_cnt_r) == cnt_t'(WD_CYC - 1))
		else $error("watchdog fired at wrong count");

	chk_wdog_in_reset: assert property (
		@(posedge clk) disable iff (!nrst)
		!reset_out_n |=> wd_cnt_r == `CNT_ZERO)
		else $error("watchdog ran under reset");

	chk_wdog_kick: assert property (
		@(posedge clk) disable iff (!nrst)
		reset_out_n && kick_fall |=> wd_cnt_r == `CNT_ZERO)
		else $error("kick did not restart watchdog");

	chk_wdog_flag_width: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(watchdog_flag_n) |-> $past(a_wdf_r) >= cnt_t'(RST_CYC - 1))
		else $error("watchdog flag too short");

endmodule : supply_button_watchdog_supervisor

//--- hdl/supervisor_cfg.svh
// Timing constants for the supply, button and watchdog supervisor.
// Assumes a single 25 MHz clock; counts derive from the times below.
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// Clock rate in hertz
`define CLK_HZ 25000000
// Reset stretch, milliseconds
`define RST_MS 130
// Interrupt pulse, microseconds
`define IRQ_US 200
// Sense low filter, microseconds
`define FILT_US 5
// Watchdog timeout, seconds
`define WD_S 1
// Button low minimum, nanoseconds
`define DEB_NS 150

// Derived cycle counts (least times round up)
`define RST_CYC (`RST_MS * (`CLK_HZ / 1000))
`define IRQ_CYC (`IRQ_US * (`CLK_HZ / 1000000))
`define FILT_CYC (`FILT_US * (`CLK_HZ / 1000000))
`define WD_CYC (`WD_S * `CLK_HZ)
`define DEB_CYC ((`DEB_NS * (`CLK_HZ / 1000000) + 999) / 1000)

// Counter width and zero
`define CNT_W 32
`define CNT_ZERO 32'h0

`endif

//--- hdl/supervisor_pkg.sv
// Types shared by the supervisor design.
// Assumes supervisor_cfg.svh supplies the counter width.
`include "supervisor_cfg.svh"

package supervisor_pkg;
	// Generic duration counter
	typedef logic [`CNT_W-1:0] cnt_t;
	// Reset sequencer states
	typedef enum logic [1:0] {
		RS_HOLD = 2'b00,
		RS_STRETCH = 2'b01,
		RS_RUN = 2'b10
	} rst_state_t;
endpackage : supervisor_pkg

//--- testbench/kick_model.sv
// Processor model that strobes the supervisor watchdog.
// Assumes one clk shared with the supervisor; strobe idles high.
`timescale 1ns/1ns

module kick_model #(
	parameter int KICK_GAP = 60
) (
	// Clock
	input wire logic clk,
	// Processor state
	input wire logic reset_out_n,
	input wire logic run,
	// Strobe to the supervisor
	output logic watchdog_kick = 1'b1
);
	int gap_cnt = 0; // Cycles since last kick

	// One low strobe cycle per gap, only out of reset
	always @(posedge clk) begin
		if (!reset_out_n || !run) begin
			gap_cnt <= 0;
			watchdog_kick <= 1'b1;
		end else begin
			gap_cnt <= (gap_cnt == KICK_GAP - 1) ? 0 : gap_cnt + 1;
			watchdog_kick <= (gap_cnt != KICK_GAP - 1);
		end
	end
endmodule : kick_model

//--- testbench/supply_button_watchdog_supervisor_tb.sv
// Self-checking bench for the supervisor with shortened timing.
// Assumes kick_model plays the processor and the design sits in hdl/.
`timescale 1ns/1ns

module supply_button_watchdog_supervisor_tb;
	localparam int RST = 40; // Reset stretch
	localparam int IRQ = 20; // Interrupt pulse
	localparam int FILT = 5; // Sense filter
	localparam int WD = 100; // Watchdog period
	localparam int DEB = 4; // Button debounce
	logic clk = 1'b0; // Clock
	logic nrst = 1'b0; // Bench reset
	logic supply_ok = 1'b1; // Supply level
	logic sense_ok = 1'b1; // Sense level
	logic button_reset_n = 1'b1; // Pushbutton
	logic run = 1'b1; // Kicks enabled
	logic loop_wdf = 1'b0; // Watchdog flag looped into the button
	wire logic watchdog_kick; // Strobe
	wire logic reset_out_n, reset_out, power_fail_irq_n, watchdog_flag_n;
	wire logic [2:0] outs = {watchdog_flag_n, power_fail_irq_n, reset_out_n};
	int errors = 0;
	int tests_run = 0;
	int n; // Measured cycles
	int len; // Random hold

	always #20 clk = ~clk;

	supply_button_watchdog_supervisor #(.RST_CYC(RST), .IRQ_CYC(IRQ), .FILT_CYC(FILT),
		.WD_CYC(WD), .DEB_CYC(DEB)) DUT (.clk(clk), .nrst(nrst), .supply_ok(supply_ok),
		.sense_ok(sense_ok),
		.button_reset_n(button_reset_n & (watchdog_flag_n | ~loop_wdf)),
		.watchdog_kick(watchdog_kick),
		.reset_out_n(reset_out_n), .reset_out(reset_out),
		.power_fail_irq_n(power_fail_irq_n), .watchdog_flag_n(watchdog_flag_n));

	kick_model #(.KICK_GAP(60)) cpu (.clk(clk), .reset_out_n(reset_out_n), .run(run),
		.watchdog_kick(watchdog_kick));

	// Edges until an output reaches a level, capped
	task automatic wait_sig(input int s, input logic v, input int mx, output int c);
		c = 0;
		while (outs[s] !== v && c < mx) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask : wait_sig

	// Count against a window
	task automatic chk(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			errors++;
			$display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
		end
	endtask : chk

	// Move one input at the next edge
	task automatic drv(input int s, input logic v);
		@(posedge clk);
		case (s)
			0: supply_ok <= v;
			1: sense_ok <= v;
			2: button_reset_n <= v;
			3: run <= v;
			default: loop_wdf <= v;
		endcase
	endtask : drv

	// Verdict and stop
	task automatic end_sim;
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// Both reset outputs always opposite
	always @(negedge clk) begin
		if (nrst && reset_out !== ~reset_out_n) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, reset_out, ~reset_out_n);
		end
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim;
	end

	// Main sequence
	initial begin
		void'($urandom(32'h810167fd));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		wait_sig(0, 1, RST + 10, n);
		chk(n, RST, RST + 4);
		// Supply dip with no kicks: watchdog frozen
		drv(3, 0);
		drv(0, 0);
		wait_sig(0, 0, 5, n);
		chk(n, 1, 2);
		wait_sig(2, 0, WD + 50, n);
		chk(n, WD + 50, WD + 50);
		drv(3, 1);
		drv(0, 1);
		wait_sig(0, 1, RST + 10, n);
		chk(n, RST, RST + 3);
		// Bounce too short to count
		drv(2, 0);
		repeat (DEB - 1) @(posedge clk);
		button_reset_n <= 1'b1;
		wait_sig(0, 0, 12, n);
		chk(n, 12, 12);
		// Held press of random length
		len = 20 + $urandom % 30;
		drv(2, 0);
		wait_sig(0, 0, DEB + 5, n);
		chk(n, DEB, DEB + 3);
		repeat (len) @(posedge clk);
		#1;
		chk(reset_out_n === 1'b0, 1, 1);
		drv(2, 1);
		wait_sig(0, 1, RST + DEB + 10, n);
		chk(n, RST, RST + DEB + 4);
		// Sense dip shorter than filter
		drv(1, 0);
		repeat (FILT - 1) @(posedge clk);
		sense_ok <= 1'b1;
		wait_sig(1, 0, 12, n);
		chk(n, 12, 12);
		drv(1, 0);
		wait_sig(1, 0, FILT + 5, n);
		chk(n, FILT, FILT + 2);
		wait_sig(1, 1, IRQ + 10, n);
		chk(n, IRQ, IRQ + 3);
		wait_sig(1, 0, 30, n);
		chk(n, 30, 30);
		// Low sense while supply low stays quiet
		drv(0, 0);
		drv(1, 1);
		drv(1, 0);
		wait_sig(1, 0, 30, n);
		chk(n, 30, 30);
		drv(0, 1);
		wait_sig(1, 0, FILT + 5, n);
		chk(n, FILT, FILT + 2);
		wait_sig(1, 1, IRQ + 10, n);
		drv(1, 1);
		wait_sig(0, 1, RST + 10, n);
		// Regular kicks hold off the watchdog
		wait_sig(2, 0, 400, n);
		chk(n, 400, 400);
		@(negedge watchdog_kick);
		run <= 1'b0;
		wait_sig(2, 0, WD + 10, n);
		chk(n, WD, WD + 3);
		wait_sig(2, 1, RST + 10, n);
		chk(n, RST, RST + 3);
		// Flag looped into the button forces a reset
		drv(4, 1);
		wait_sig(2, 0, WD, n);
		chk(n, WD - RST - 3, WD - RST);
		wait_sig(0, 0, DEB + 5, n);
		chk(n, DEB, DEB + 3);
		end_sim;
	end
endmodule : supply_button_watchdog_supervisor_tb
